/* File: pin_mux_map.svh */
// pin mux constants: pin indices, clock rate, pulse generator limits
// assumes a single 40 MHz core clock
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH

`define PIN_COUNT        9
`define PIN_GP1          0
`define PIN_GP2          1
`define PIN_GP3          2
`define PIN_GP4          3
`define PIN_GP6          5
`define PIN_GP7          6
`define PIN_GP8          7
`define PIN_GP9          8

`define CLK_HZ           40000000
`define PULSE_FMAX_HZ    6000000
`define PULSE_FMIN_MHZ   60
`define PULSE_MIN_PERIOD ((`CLK_HZ + `PULSE_FMAX_HZ - 1) / `PULSE_FMAX_HZ)
`define PULSE_MAX_PERIOD ((64'(`CLK_HZ) * 64'h3E8) / 64'(`PULSE_FMIN_MHZ))

`define SYNC_RESET       1'h1
`define COUNT_WIDTH      32
`define PERIOD_WIDTH     30

`endif

/* File: pin_mux_pkg.sv */
// pin mux types: pin function codes and per-pin configuration
// assumes nothing beyond the map header
package pin_mux_pkg;
    typedef enum logic [3:0] {
        FN_INPUT,
        FN_OUTPUT,
        FN_PULSE,
        FN_ANALOG,
        FN_HOST_RX,
        FN_HOST_TX,
        FN_HOST_DE,
        FN_SPI_CS,
        FN_SPI_CLK
    } pinFunc_t;

    typedef struct packed {
        pinFunc_t func;
        logic     countEn;
    } pinCfg_t;
endpackage

/* File: multifunction_pin_mux.sv */
// multi-function header pin selector with shared pulse generator and pulse counters
// assumes config, data and driver-activity inputs come from logic on clk;
// pad inputs are asynchronous and are synchronised here
`include "pin_mux_map.svh"

// Summary of operation
// - the seventh pin offers digital in, digital out, pulse out, pulse count and host transmit data.
// - the third and seventh pins share one pulse generator and so one waveform setting.
// - the pulse is left aligned, high at period start, from 0.06 Hz to 6 MHz, 0 to 100 % duty.
// - a pin's pulse counter runs alongside whatever other function that pin has.
// - the network driver enable is high while network data is sent and low otherwise.
// - the eighth pin as host driver enable is high while host data is sent and low otherwise.
// - the eighth pin offers digital in, digital out, pulse count, host driver enable and chip select in, no pulse.
// - the ninth pin as SPI clock is an input driven by the master's clock output.
// - the first and second pins offer digital in, digital out, analog in and pulse count, no pulse.
// - the sixth pin as receive data is the host serial input paired with the seventh pin's transmit.
module multifunction_pin_mux #(
    parameter int COUNT_W  = `COUNT_WIDTH,
    parameter int PERIOD_W = `PERIOD_WIDTH
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire pin_mux_pkg::pinCfg_t      pinCfg [`PIN_COUNT],
    input  wire logic [`PIN_COUNT-1:0]     gpioOutData,
    input  wire logic [`PIN_COUNT-1:0]     countClear,
    input  wire logic [PERIOD_W-1:0]       pulsePeriod,
    input  wire logic [PERIOD_W-1:0]       pulseHigh,
    input  wire logic                      networkTxActive,
    input  wire logic                      hostTxData,
    input  wire logic                      hostTxActive,
    input  wire logic [`PIN_COUNT-1:0]     padIn,
    output logic [`PIN_COUNT-1:0]          padOut,
    output logic [`PIN_COUNT-1:0]          padOe,
    output logic [`PIN_COUNT-1:0]          gpioInData,
    output logic [COUNT_W-1:0]             pulseCount [`PIN_COUNT],
    output logic                           network_driver_enable,
    output logic                           analog_input_one,
    output logic                           analog_input_two,
    output logic                           hostRxData,
    output logic                           spiCsN,
    output logic                           spiClk
);
    localparam logic [63:0] MAX_PERIOD = `PULSE_MAX_PERIOD;
    localparam int          MIN_PERIOD = `PULSE_MIN_PERIOD;

    if (PERIOD_W < $clog2(MAX_PERIOD + 64'h1) || PERIOD_W > 63) begin : g_bad_period
        $error("PERIOD_W cannot hold the slowest pulse period");
    end
    if (COUNT_W < 1) begin : g_bad_count
        $error("COUNT_W must be at least one bit");
    end

    // which functions each pin may take; anything else leaves the pad released
    // and unsampled except by its pulse counter, so a bad setting can never fight an external driver
    function automatic logic fnLegal(input int idx, input pin_mux_pkg::pinFunc_t fn);
        logic ok;
        ok = 1'h0;
        unique case (fn)
            pin_mux_pkg::FN_INPUT, pin_mux_pkg::FN_OUTPUT: ok = 1'h1;
            pin_mux_pkg::FN_PULSE:   ok = (idx == `PIN_GP3) || (idx == `PIN_GP7);
            pin_mux_pkg::FN_ANALOG:  ok = (idx == `PIN_GP1) || (idx == `PIN_GP2);
            pin_mux_pkg::FN_HOST_RX: ok = (idx == `PIN_GP6);
            pin_mux_pkg::FN_HOST_TX: ok = (idx == `PIN_GP7);
            pin_mux_pkg::FN_HOST_DE: ok = (idx == `PIN_GP8);
            pin_mux_pkg::FN_SPI_CS:  ok = (idx == `PIN_GP8);
            pin_mux_pkg::FN_SPI_CLK: ok = (idx == `PIN_GP9);
            default:                 ok = 1'h0;
        endcase
        return ok;
    endfunction

    function automatic logic isFn(input int idx, input pin_mux_pkg::pinFunc_t fn);
        return (pinCfg[idx].func == fn) && fnLegal(idx, fn);
    endfunction

    // pad synchronisers; stage one feeds stage two only
    logic [`PIN_COUNT-1:0] syncA_r;
    logic [`PIN_COUNT-1:0] syncB_r;
    logic [`PIN_COUNT-1:0] syncPrev_r;

    always_ff @(posedge clk or posedge rst) begin
        // reset to the pulled-up idle level so no false count edge follows reset
        if (rst) begin
            syncA_r    <= {`PIN_COUNT{`SYNC_RESET}};
            syncB_r    <= {`PIN_COUNT{`SYNC_RESET}};
            syncPrev_r <= {`PIN_COUNT{`SYNC_RESET}};
        end else begin
            syncA_r    <= padIn;
            syncB_r    <= syncA_r;
            syncPrev_r <= syncB_r;
        end
    end

    // shared pulse generator
    logic [PERIOD_W-1:0] pulseCnt_r;
    logic [PERIOD_W-1:0] pulseCnt_nxt;
    logic                pulseLvl_r;
    logic                pulseLvl_nxt;
    logic [PERIOD_W-1:0] periodEff;

    always_comb begin
        periodEff = pulsePeriod;
        if (64'(pulsePeriod) < 64'(MIN_PERIOD)) begin
            periodEff = PERIOD_W'(MIN_PERIOD);
        end else if (64'(pulsePeriod) > MAX_PERIOD) begin
            periodEff = PERIOD_W'(MAX_PERIOD);
        end
        pulseCnt_nxt = pulseCnt_r + PERIOD_W'(1);
        if (pulseCnt_r >= periodEff - PERIOD_W'(1)) begin
            pulseCnt_nxt = '0;
        end
        pulseLvl_nxt = (pulseCnt_nxt < pulseHigh);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulseCnt_r <= '0;
            pulseLvl_r <= 1'h0;
        end else begin
            pulseCnt_r <= pulseCnt_nxt;
            pulseLvl_r <= pulseLvl_nxt;
        end
    end

    // per-pin drive, sampling and counting
    logic [`PIN_COUNT-1:0] padOut_nxt;
    logic [`PIN_COUNT-1:0] padOe_nxt;
    logic [`PIN_COUNT-1:0] gpioIn_nxt;
    logic [COUNT_W-1:0]    count_nxt [`PIN_COUNT];

    for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_pin
        always_comb begin
            padOut_nxt[i] = 1'h0;
            padOe_nxt[i]  = 1'h0;
            if (isFn(i, pin_mux_pkg::FN_OUTPUT)) begin
                padOut_nxt[i] = gpioOutData[i];
                padOe_nxt[i]  = 1'h1;
            end else if (isFn(i, pin_mux_pkg::FN_PULSE)) begin
                padOut_nxt[i] = pulseLvl_r;
                padOe_nxt[i]  = 1'h1;
            end else if (isFn(i, pin_mux_pkg::FN_HOST_TX)) begin
                padOut_nxt[i] = hostTxData;
                padOe_nxt[i]  = 1'h1;
            end else if (isFn(i, pin_mux_pkg::FN_HOST_DE)) begin
                padOut_nxt[i] = hostTxActive;
                padOe_nxt[i]  = 1'h1;
            end
            gpioIn_nxt[i] = gpioInData[i];
            if (isFn(i, pin_mux_pkg::FN_INPUT)) begin
                gpioIn_nxt[i] = syncB_r[i];
            end
            count_nxt[i] = pulseCount[i];
            if (pinCfg[i].countEn && syncB_r[i] && !syncPrev_r[i]) begin
                // an edge in the clear cycle survives as a count of one
                count_nxt[i] = countClear[i] ? COUNT_W'(1) : pulseCount[i] + COUNT_W'(1);
            end else if (countClear[i]) begin
                count_nxt[i] = '0;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                padOut[i]     <= 1'h0;
                padOe[i]      <= 1'h0;
                gpioInData[i] <= 1'h0;
                pulseCount[i] <= '0;
            end else begin
                padOut[i]     <= padOut_nxt[i];
                padOe[i]      <= padOe_nxt[i];
                gpioInData[i] <= gpioIn_nxt[i];
                pulseCount[i] <= count_nxt[i];
            end
        end
    end

    // host link, SPI pins, analog selects, network enable
    logic rxNxt;
    logic csNxt;
    logic sckNxt;
    logic an1Nxt;
    logic an2Nxt;

    always_comb begin
        // host receive input, idle high when unselected
        rxNxt  = isFn(`PIN_GP6, pin_mux_pkg::FN_HOST_RX) ? syncB_r[`PIN_GP6] : 1'h1;
        // chip select input, deselected unless chosen
        csNxt  = isFn(`PIN_GP8, pin_mux_pkg::FN_SPI_CS) ? syncB_r[`PIN_GP8] : 1'h1;
        sckNxt = isFn(`PIN_GP9, pin_mux_pkg::FN_SPI_CLK) ? syncB_r[`PIN_GP9] : 1'h0;
        // analog select on first two pins
        an1Nxt = isFn(`PIN_GP1, pin_mux_pkg::FN_ANALOG);
        an2Nxt = isFn(`PIN_GP2, pin_mux_pkg::FN_ANALOG);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hostRxData            <= 1'h1;
            spiCsN                <= 1'h1;
            spiClk                <= 1'h0;
            analog_input_one      <= 1'h0;
            analog_input_two      <= 1'h0;
            network_driver_enable <= 1'h0;
        end else begin
            hostRxData            <= rxNxt;
            spiCsN                <= csNxt;
            spiClk                <= sckNxt;
            analog_input_one      <= an1Nxt;
            analog_input_two      <= an2Nxt;
            network_driver_enable <= networkTxActive;
        end
    end
endmodule

/* File: mux_chk_sva.sv */
// assertions on the pin selector ports
// assumes one clock domain, reset active high
`include "pin_mux_map.svh"
module mux_chk (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire pin_mux_pkg::pinCfg_t  pinCfg [`PIN_COUNT],
    input wire logic [`PIN_COUNT-1:0] padIn,
    input wire logic [`PIN_COUNT-1:0] padOut,
    input wire logic [`PIN_COUNT-1:0] padOe,
    input wire logic                  networkTxActive,
    input wire logic                  hostTxData,
    input wire logic                  hostTxActive,
    input wire logic                  network_driver_enable,
    input wire logic                  spiCsN
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_net_de_copy: assert property (##1 network_driver_enable == $past(networkTxActive))
        else $error("network enable wrong");
    a_host_de_pin: assert property (pinCfg[7].func == pin_mux_pkg::FN_HOST_DE |=>
        padOe[7] && padOut[7] == $past(hostTxActive)) else $error("host enable wrong");
    a_tx_pin: assert property (pinCfg[6].func == pin_mux_pkg::FN_HOST_TX |=>
        padOe[6] && padOut[6] == $past(hostTxData)) else $error("host transmit wrong");
    a_pin8_no_pulse: assert property (pinCfg[7].func == pin_mux_pkg::FN_PULSE |=>
        !padOe[7]) else $error("pin 8 pulse driven");
    a_pin1_no_pulse: assert property (pinCfg[0].func == pin_mux_pkg::FN_PULSE |=>
        !padOe[0]) else $error("pin 1 pulse driven");
    a_clk_input: assert property (pinCfg[8].func == pin_mux_pkg::FN_SPI_CLK |=>
        !padOe[8]) else $error("serial clock pin driven");
    a_cs_follow: assert property ((pinCfg[7].func == pin_mux_pkg::FN_SPI_CS) [*4] |->
        spiCsN == $past(padIn[7], 3)) else $error("select not followed");
    a_cs_idle: assert property (pinCfg[7].func != pin_mux_pkg::FN_SPI_CS |=> spiCsN)
        else $error("select not idle");
    a_pulse_shared: assert property ((pinCfg[2].func == pin_mux_pkg::FN_PULSE &&
        pinCfg[6].func == pin_mux_pkg::FN_PULSE) [*3] |-> padOut[2] == padOut[6])
        else $error("pulse pins differ");
    cover property (spiCsN ##1 !spiCsN);
    cover property ($rose(network_driver_enable));
    cover property ($rose(padOut[2]));
endmodule
bind multifunction_pin_mux mux_chk u_chk (.clk(clk), .rst(rst), .pinCfg(pinCfg),
    .padIn(padIn), .padOut(padOut), .padOe(padOe), .networkTxActive(networkTxActive),
    .hostTxData(hostTxData), .hostTxActive(hostTxActive),
    .network_driver_enable(network_driver_enable), .spiCsN(spiCsN));

/* File: far_side.sv */
// far side: serial master on pins 8 and 9, other drivers, pull-ups
// assumes the bench changes extDrv and extOe just after clk rises
`include "pin_mux_map.svh"
module far_side (
    input  wire logic                  clk,
    input  wire logic [`PIN_COUNT-1:0] padOut,
    input  wire logic [`PIN_COUNT-1:0] padOe,
    input  wire logic [`PIN_COUNT-1:0] extDrv,
    input  wire logic [`PIN_COUNT-1:0] extOe,
    output logic [`PIN_COUNT-1:0]      padIn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic csN = 1'h1;
    logic sck = 1'h0;
    // a released pad floats high through the pull-up
    always_comb begin
        padIn = (extDrv & extOe) | ~extOe;
        padIn[7] = csN;
        padIn[8] = sck;
        padIn = (padOut & padOe) | (padIn & ~padOe);
    end
    // select low all frame, clock still outside it
    task automatic frame(input int edges);
        @(posedge clk) #2 csN = 1'h0;
        repeat (edges) begin
            repeat (4) @(posedge clk);
            #2 sck = 1'h1;
            repeat (4) @(posedge clk);
            #2 sck = 1'h0;
        end
        repeat (4) @(posedge clk);
        #2 csN = 1'h1;
    endtask
endmodule

/* File: tb_top.sv */
// bench for the pin selector: random traffic plus corner cases
// assumes far_side resolves every pad and the checker is bound in
`include "pin_mux_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 clk = 1'h0;
    logic                 rst = 1'h1;
    pin_mux_pkg::pinCfg_t cfg [`PIN_COUNT];
    logic [8:0]           outData = 9'h0, clr = 9'h0, extDrv = 9'h0, extOe = 9'h0;
    logic [8:0]           padIn, padOut, padOe, gpioIn;
    logic [29:0]          per = 30'hA, hi = 30'h3;
    logic [29:0]          pEff;
    logic                 netAct = 1'h0, txData = 1'h0, txAct = 1'h0;
    logic                 netDe, ana1, ana2, rxData, csN, sck;
    logic [31:0]          cnt [`PIN_COUNT];
    logic [31:0]          hiSeen;
    int                   seed = 62, num_errors = 0, checked = 0, cycles = 0, n;
    multifunction_pin_mux dut (.clk(clk), .rst(rst), .pinCfg(cfg), .gpioOutData(outData),
        .countClear(clr), .pulsePeriod(per), .pulseHigh(hi), .networkTxActive(netAct),
        .hostTxData(txData), .hostTxActive(txAct), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .gpioInData(gpioIn), .pulseCount(cnt), .network_driver_enable(netDe),
        .analog_input_one(ana1), .analog_input_two(ana2), .hostRxData(rxData),
        .spiCsN(csN), .spiClk(sck));
    far_side far (.clk(clk), .padOut(padOut), .padOe(padOe), .extDrv(extDrv),
        .extOe(extOe), .padIn(padIn));
    always #12.5 clk = ~clk;
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // two periods of high time; a high count past the period saturates
    function automatic logic [31:0] expHigh(input logic [29:0] p, input logic [29:0] h);
        return 32'((h > p) ? p : h) << 1;
    endfunction
    task automatic finish_test();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ceiling well above the roughly 800 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        foreach (cfg[i]) cfg[i] = '{pin_mux_pkg::FN_INPUT, 1'h0};
        step(2);
        check({padOe, csN, rxData, netDe}, 32'h6);
        rst = 1'h0;
        cfg[5].func = pin_mux_pkg::FN_HOST_RX;
        extOe = 9'h021;
        for (n = 0; n < 4; n++) begin
            extDrv = 9'($random(seed));
            step(5);
            check({rxData, gpioIn[0]}, {extDrv[5], extDrv[0]});
        end
        cfg[7].func = pin_mux_pkg::FN_HOST_DE;
        for (n = 0; n < 200; n++) begin
            cfg[6].func = n[0] ? pin_mux_pkg::FN_HOST_TX : pin_mux_pkg::FN_OUTPUT;
            {netAct, txData, txAct} = 3'($random(seed));
            outData = 9'($random(seed));
            step(1);
            check(netDe, netAct);
            check(padOut[7] & padOe[7], txAct);
            check(padOut[6], n[0] ? txData : outData[6]);
        end
        cfg[7].func = pin_mux_pkg::FN_PULSE;
        cfg[0].func = pin_mux_pkg::FN_ANALOG;
        cfg[1].func = pin_mux_pkg::FN_ANALOG;
        step(2);
        check({padOe[7], padOe[1:0], ana1, ana2}, 32'h3);
        cfg[6] = '{pin_mux_pkg::FN_OUTPUT, 1'h1};
        cfg[7] = '{pin_mux_pkg::FN_SPI_CS, 1'h0};
        cfg[8] = '{pin_mux_pkg::FN_SPI_CLK, 1'h1};
        outData = 9'h0;
        clr = 9'h1FF;
        step(4);
        clr = 9'h0;
        repeat (3) begin
            outData[6] = 1'h1;
            step(4);
            outData[6] = 1'h0;
            step(4);
        end
        // select and clock seen mid frame, three edges behind the pads
        fork
            far.frame(5);
            begin
                step(8);
                check({csN, sck}, 32'h1);
            end
        join
        step(4);
        check(cnt[6], 32'h3);
        check(cnt[8], 32'h5);
        check({csN, sck}, 32'h2);
        cfg[0].func = pin_mux_pkg::FN_PULSE;
        cfg[2].func = pin_mux_pkg::FN_PULSE;
        cfg[6].func = pin_mux_pkg::FN_PULSE;
        // periods grow, then a last corner below the minimum must be clamped
        for (n = 0; n < 7; n++) begin
            per = (n == 6) ? 30'h3 : 30'(7 + 2 * n + ($unsigned($random(seed)) % 2));
            hi = (n == 0) ? 30'h0 : (n == 1) ? per : (n == 6) ? 30'h2 :
                30'($unsigned($random(seed)) % 22);
            pEff = (per < 30'(`PULSE_MIN_PERIOD)) ? 30'(`PULSE_MIN_PERIOD) : per;
            step(48);
            hiSeen = 32'h0;
            repeat (2 * pEff) begin
                hiSeen += 32'(padOut[2]);
                step(1);
            end
            check(hiSeen, expHigh(pEff, hi));
        end
        check({padOe[0], ana1}, 32'h0);
        finish_test();
    end
endmodule
